// file: amst_map.svh
// amst_map.svh: field widths and timing constants of the async memory strobe sequencer
`ifndef AMST_MAP_SVH
`define AMST_MAP_SVH
`define AMST_ADDR_W 21
`define AMST_BANK_W 2
`define AMST_DATA_W 16
`define AMST_CS_W 4
`define AMST_CNT_W 6
`define AMST_WAITCNT_W 8
`define AMST_EW_STEP 16
`define AMST_WAIT_RELEASE 4
`define AMST_FIFO_DEPTH 8
`define AMST_REQ_W 42
`endif

// file: amst_pkg.sv
// amst_pkg.sv: types of the async memory strobe sequencer
`include "amst_map.svh"
package amst_pkg;
   typedef logic [`AMST_CNT_W-1:0] amst_cnt_t;
   typedef logic [`AMST_WAITCNT_W-1:0] amst_wcnt_t;
   typedef enum logic [2:0] {
      AMST_IDLE = 3'b000,
      AMST_TURN = 3'b001,
      AMST_SETUP = 3'b010,
      AMST_STROBE = 3'b011,
      AMST_EXTW = 3'b100,
      AMST_REL = 3'b101,
      AMST_HOLD = 3'b110
   } amst_state_t;
endpackage : amst_pkg

// file: amst_fifo.sv
// amst_fifo.sv: flip-flop request FIFO with valid/ready on both sides
`timescale 1ns/1ps
module amst_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, rp_r, wp_nxt, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;
   assign push = in_valid_i && (cnt_r != (AW+1)'(DEPTH));
   assign pop = out_ready_i && (cnt_r != '0);
   assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o = mem_r[rp_r];
   always_comb begin
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end
endmodule : amst_fifo

// file: amst_ctrl.sv
// amst_ctrl.sv: setup/strobe/hold sequencer for asynchronous SRAM and NOR flash
// How it works
// - with wait off, a read lasts read setup plus strobe plus hold cycles.
// - with wait on, a read grows sixteen cycles per external wait cycle.
// - address and bank are valid read-setup cycles before output enable falls.
// - address and bank stay unchanged read-hold cycles after output enable rises.
// - output enable stays low strobe cycles, plus sixteen per wait cycle.
// - output enable rises four cycles after the synchronised wait drops, six after the wait input drops.
// - select-strobe off, chip select falls at the start of read setup.
// - select-strobe on, chip select follows the strobe exactly for reads and writes.
// - select-strobe off, chip select stays low through read hold.
// - with wait off, a write lasts write setup plus strobe plus hold cycles.
// - with wait on, a write grows sixteen cycles per external wait cycle.
// - address and bank are valid write-setup cycles before write enable falls.
// - address and bank stay unchanged write-hold cycles after write enable rises.
// - select-strobe off, chip select falls write-setup cycles before write enable.
// - select-strobe off, chip select stays low through write hold.
// - setup, strobe, hold and turnaround counts and the wait limit are programmable inputs; the sixteen-cycle wait step and release are fixed.
// - wait cycles are counted from the wait input; the limit ends waiting.
// - write enable stays low strobe cycles, plus sixteen per wait cycle.
`timescale 1ns/1ps
`include "amst_map.svh"
module amst_ctrl (
   input wire logic clk_i,
   input wire logic nrst_i,
   // request stream: write flag, chip select index, bank, address, write data
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_write_i,
   input wire logic [1:0] req_cs_i,
   input wire logic [`AMST_BANK_W-1:0] req_bank_i,
   input wire logic [`AMST_ADDR_W-1:0] req_addr_i,
   input wire logic [`AMST_DATA_W-1:0] req_wdata_i,
   output logic rsp_valid_o,
   output logic [`AMST_DATA_W-1:0] rsp_rdata_o,
   output logic rsp_timeout_o,
   // configuration
   input wire logic select_strobe_i,
   input wire logic extended_wait_enable_i,
   input wire logic wait_polarity_i,
   input wire amst_pkg::amst_cnt_t turnaround_cycles_i,
   input wire amst_pkg::amst_cnt_t read_setup_cycles_i,
   input wire amst_pkg::amst_cnt_t read_strobe_cycles_i,
   input wire amst_pkg::amst_cnt_t read_hold_cycles_i,
   input wire amst_pkg::amst_cnt_t write_setup_cycles_i,
   input wire amst_pkg::amst_cnt_t write_strobe_cycles_i,
   input wire amst_pkg::amst_cnt_t write_hold_cycles_i,
   input wire amst_pkg::amst_wcnt_t max_wait_limit_i,
   output logic busy_o,
   // memory pins
   output logic [`AMST_CS_W-1:0] async_chip_select_n_o,
   output logic output_enable_n_o,
   output logic write_enable_n_o,
   output logic [`AMST_ADDR_W-1:0] ext_address_o,
   output logic [`AMST_BANK_W-1:0] ext_bank_address_o,
   input wire logic [`AMST_DATA_W-1:0] ext_data_i,
   output logic [`AMST_DATA_W-1:0] ext_data_o,
   output logic ext_data_oe_o,
   input wire logic memory_wait_in_i
);
   import amst_pkg::*;

   // ------------------------------------------------------------
   // request buffer
   // ------------------------------------------------------------
   logic f_valid, f_pop;
   logic [`AMST_REQ_W-1:0] f_data;
   amst_fifo #(.WIDTH(`AMST_REQ_W), .DEPTH(`AMST_FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(req_valid_i),
      .in_ready_o(req_ready_o),
      .in_data_i({req_write_i, req_cs_i, req_bank_i, req_addr_i, req_wdata_i}),
      .out_valid_o(f_valid),
      .out_ready_i(f_pop),
      .out_data_o(f_data)
   );

   // ------------------------------------------------------------
   // wait input synchroniser
   // ------------------------------------------------------------
   logic wait_s1_r, wait_s2_r, wait_act;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wait_s1_r <= 1'b0;
         wait_s2_r <= 1'b0;
      end else begin
         wait_s1_r <= memory_wait_in_i;
         wait_s2_r <= wait_s1_r;
      end
   end
   assign wait_act = wait_s2_r ^ wait_polarity_i;

   function automatic amst_cnt_t pick(input logic wr, input amst_cnt_t r, input amst_cnt_t w);
      pick = wr ? w : r;
   endfunction : pick

   // ------------------------------------------------------------
   // phase sequencer
   // ------------------------------------------------------------
   amst_state_t st_r, st_nxt;
   amst_cnt_t cnt_r, cnt_nxt;
   amst_wcnt_t ewc_r, ewc_nxt;
   logic [3:0] sub_r, sub_nxt;
   logic wr_r, wr_nxt, last_wr_r, last_wr_nxt, used_r, used_nxt;
   logic [1:0] csi_r, csi_nxt;
   logic [`AMST_BANK_W-1:0] ba_r, ba_nxt;
   logic [`AMST_ADDR_W-1:0] a_r, a_nxt;
   logic [`AMST_DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
   logic cs_nxt, oe_r, oe_nxt, we_r, we_nxt, doe_r, doe_nxt;
   logic [`AMST_CS_W-1:0] cs_n_r, cs_n_nxt;
   logic busy_r, busy_nxt;
   logic rv_r, rv_nxt, to_r, to_nxt, strobe_nxt;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      ewc_nxt = ewc_r;
      sub_nxt = sub_r;
      wr_nxt = wr_r;
      last_wr_nxt = last_wr_r;
      used_nxt = used_r;
      csi_nxt = csi_r;
      ba_nxt = ba_r;
      a_nxt = a_r;
      wd_nxt = wd_r;
      rd_nxt = rd_r;
      rv_nxt = 1'b0;
      to_nxt = to_r;
      f_pop = 1'b0;
      case (st_r)
         AMST_IDLE: begin
            if (f_valid) begin
               f_pop = 1'b1;
               {wr_nxt, csi_nxt, ba_nxt, a_nxt, wd_nxt} = f_data;
               ewc_nxt = '0;
               if (used_r && (f_data[`AMST_REQ_W-1] != last_wr_r)
                   && (turnaround_cycles_i != '0)) begin
                  st_nxt = AMST_TURN;
                  cnt_nxt = turnaround_cycles_i - 1'b1;
               end else begin
                  st_nxt = AMST_SETUP;
                  cnt_nxt = pick(f_data[`AMST_REQ_W-1], read_setup_cycles_i,
                                 write_setup_cycles_i) - 1'b1;
               end
            end
         end
         AMST_TURN: begin
            if (cnt_r == '0) begin
               st_nxt = AMST_SETUP;
               cnt_nxt = pick(wr_r, read_setup_cycles_i, write_setup_cycles_i) - 1'b1;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         AMST_SETUP: begin
            if (cnt_r == '0) begin
               st_nxt = AMST_STROBE;
               cnt_nxt = pick(wr_r, read_strobe_cycles_i, write_strobe_cycles_i) - 1'b1;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         AMST_STROBE: begin
            if (cnt_r == '0) begin
               if (extended_wait_enable_i && wait_act) begin
                  st_nxt = AMST_EXTW;
                  sub_nxt = 4'(`AMST_EW_STEP - 1);
                  ewc_nxt = 8'h01;
               end else begin
                  st_nxt = AMST_HOLD;
                  rd_nxt = ext_data_i;
                  cnt_nxt = pick(wr_r, read_hold_cycles_i, write_hold_cycles_i) - 1'b1;
               end
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         AMST_EXTW: begin
            // strobe stretched in steps of sixteen cycles per wait cycle
            if (!wait_act) begin
               st_nxt = AMST_REL;
               cnt_nxt = 6'(`AMST_WAIT_RELEASE - 2);
            end else if (sub_r != '0) begin
               sub_nxt = sub_r - 1'b1;
            end else if (ewc_r >= max_wait_limit_i) begin
               st_nxt = AMST_HOLD;
               to_nxt = 1'b1;
               rd_nxt = ext_data_i;
               cnt_nxt = pick(wr_r, read_hold_cycles_i, write_hold_cycles_i) - 1'b1;
            end else begin
               sub_nxt = 4'(`AMST_EW_STEP - 1);
               ewc_nxt = ewc_r + 1'b1;
            end
         end
         AMST_REL: begin
            if (cnt_r == '0) begin
               st_nxt = AMST_HOLD;
               rd_nxt = ext_data_i;
               cnt_nxt = pick(wr_r, read_hold_cycles_i, write_hold_cycles_i) - 1'b1;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         AMST_HOLD: begin
            if (cnt_r == '0) begin
               st_nxt = AMST_IDLE;
               last_wr_nxt = wr_r;
               used_nxt = 1'b1;
               rv_nxt = !wr_r;
               if (wr_r) begin
                  to_nxt = to_r;
               end
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         default: begin
            st_nxt = AMST_IDLE;
         end
      endcase
      if (st_r == AMST_IDLE && f_valid) begin
         to_nxt = 1'b0;
      end
      // pin levels for the state being entered
      strobe_nxt = (st_nxt == AMST_STROBE) || (st_nxt == AMST_EXTW) || (st_nxt == AMST_REL);
      oe_nxt = !(strobe_nxt && !wr_nxt);
      we_nxt = !(strobe_nxt && wr_nxt);
      if (select_strobe_i) begin
         cs_nxt = strobe_nxt;
      end else begin
         cs_nxt = (st_nxt == AMST_SETUP) || strobe_nxt || (st_nxt == AMST_HOLD);
      end
      doe_nxt = wr_nxt && ((st_nxt == AMST_SETUP) || strobe_nxt || (st_nxt == AMST_HOLD));
      // one-hot select decoded ahead of the flop so the pin is glitch free
      cs_n_nxt = ~({{(`AMST_CS_W-1){1'b0}}, cs_nxt} << csi_nxt);
      busy_nxt = (st_nxt != AMST_IDLE);
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= AMST_IDLE;
         cnt_r <= '0;
         ewc_r <= '0;
         sub_r <= '0;
         wr_r <= 1'b0;
         last_wr_r <= 1'b0;
         used_r <= 1'b0;
         csi_r <= '0;
         ba_r <= '0;
         a_r <= '0;
         wd_r <= '0;
         rd_r <= '0;
         rv_r <= 1'b0;
         to_r <= 1'b0;
         cs_n_r <= {`AMST_CS_W{1'b1}};
         busy_r <= 1'b0;
         oe_r <= 1'b1;
         we_r <= 1'b1;
         doe_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         ewc_r <= ewc_nxt;
         sub_r <= sub_nxt;
         wr_r <= wr_nxt;
         last_wr_r <= last_wr_nxt;
         used_r <= used_nxt;
         csi_r <= csi_nxt;
         ba_r <= ba_nxt;
         a_r <= a_nxt;
         wd_r <= wd_nxt;
         rd_r <= rd_nxt;
         rv_r <= rv_nxt;
         to_r <= to_nxt;
         cs_n_r <= cs_n_nxt;
         busy_r <= busy_nxt;
         oe_r <= oe_nxt;
         we_r <= we_nxt;
         doe_r <= doe_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs, all from flip-flops
   // ------------------------------------------------------------
   assign async_chip_select_n_o = cs_n_r;
   assign output_enable_n_o = oe_r;
   assign write_enable_n_o = we_r;
   assign ext_address_o = a_r;
   assign ext_bank_address_o = ba_r;
   assign ext_data_o = wd_r;
   assign ext_data_oe_o = doe_r;
   assign rsp_valid_o = rv_r;
   assign rsp_rdata_o = rd_r;
   assign rsp_timeout_o = to_r;
   assign busy_o = busy_r;
endmodule : amst_ctrl

// file: amst_ctrl_props.sv
// amst_ctrl_props.sv: pin timing assertions for the strobe sequencer
`timescale 1ns/1ps
`include "amst_map.svh"
module amst_ctrl_props (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic select_strobe_i,
   input wire logic extended_wait_enable_i,
   input wire amst_pkg::amst_cnt_t read_setup_cycles_i,
   input wire amst_pkg::amst_cnt_t read_strobe_cycles_i,
   input wire amst_pkg::amst_cnt_t read_hold_cycles_i,
   input wire amst_pkg::amst_cnt_t write_setup_cycles_i,
   input wire amst_pkg::amst_cnt_t write_strobe_cycles_i,
   input wire amst_pkg::amst_cnt_t write_hold_cycles_i,
   input wire logic [`AMST_CS_W-1:0] async_chip_select_n_o,
   input wire logic output_enable_n_o,
   input wire logic write_enable_n_o,
   input wire logic [`AMST_ADDR_W-1:0] ext_address_o,
   input wire logic [`AMST_BANK_W-1:0] ext_bank_address_o
);
   import amst_pkg::*;
   // ---------------------------------------------
   // run-length counters of the active-low pins
   // ---------------------------------------------
   logic [9:0] oe_c_r, we_c_r, cs_c_r, oe_c_nxt, we_c_nxt, cs_c_nxt;
   logic rd_r, rd_nxt, cs_on;
   always_comb begin
      cs_on = async_chip_select_n_o != 4'hf;
      oe_c_nxt = output_enable_n_o ? 10'h000 : oe_c_r + 10'h001;
      we_c_nxt = write_enable_n_o ? 10'h000 : we_c_r + 10'h001;
      cs_c_nxt = cs_on ? cs_c_r + 10'h001 : 10'h000;
      // remembers the direction of the access that owns the select
      rd_nxt = !output_enable_n_o ? 1'b1 : (!write_enable_n_o ? 1'b0 : rd_r);
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         oe_c_r <= 10'h000;
         we_c_r <= 10'h000;
         cs_c_r <= 10'h000;
         rd_r <= 1'b0;
      end else begin
         oe_c_r <= oe_c_nxt;
         we_c_r <= we_c_nxt;
         cs_c_r <= cs_c_nxt;
         rd_r <= rd_nxt;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_rd_setup_len: assert property (
      $fell(output_enable_n_o) && !select_strobe_i |-> cs_c_r == read_setup_cycles_i)
      else $error("read setup length wrong");
   a_wr_setup_len: assert property (
      $fell(write_enable_n_o) && !select_strobe_i |-> cs_c_r == write_setup_cycles_i)
      else $error("write setup length wrong");
   a_oe_low_width: assert property (
      $rose(output_enable_n_o) && !extended_wait_enable_i |-> oe_c_r == read_strobe_cycles_i)
      else $error("output enable width wrong");
   a_we_low_width: assert property (
      $rose(write_enable_n_o) && !extended_wait_enable_i |-> we_c_r == write_strobe_cycles_i)
      else $error("write enable width wrong");
   a_rd_cycle_len: assert property (
      $fell(cs_on) && rd_r && !select_strobe_i && !extended_wait_enable_i |->
      cs_c_r == read_setup_cycles_i + read_strobe_cycles_i + read_hold_cycles_i)
      else $error("read cycle length wrong");
   a_wr_cycle_len: assert property (
      $fell(cs_on) && !rd_r && !select_strobe_i && !extended_wait_enable_i |->
      cs_c_r == write_setup_cycles_i + write_strobe_cycles_i + write_hold_cycles_i)
      else $error("write cycle length wrong");
   a_sel_follows_strobe: assert property (
      select_strobe_i |-> cs_on == (!output_enable_n_o || !write_enable_n_o))
      else $error("select does not follow strobe");
   a_addr_held_stable: assert property (
      cs_on && $past(cs_on) |-> $stable(ext_address_o) && $stable(ext_bank_address_o))
      else $error("address moved during access");
   a_strobes_exclusive: assert property (
      !(output_enable_n_o == 1'b0 && write_enable_n_o == 1'b0))
      else $error("both strobes low");
endmodule : amst_ctrl_props
bind amst_ctrl amst_ctrl_props u_props (.clk_i(clk_i), .nrst_i(nrst_i),
   .select_strobe_i(select_strobe_i), .extended_wait_enable_i(extended_wait_enable_i),
   .read_setup_cycles_i(read_setup_cycles_i), .read_strobe_cycles_i(read_strobe_cycles_i),
   .read_hold_cycles_i(read_hold_cycles_i), .write_setup_cycles_i(write_setup_cycles_i),
   .write_strobe_cycles_i(write_strobe_cycles_i), .write_hold_cycles_i(write_hold_cycles_i),
   .async_chip_select_n_o(async_chip_select_n_o), .output_enable_n_o(output_enable_n_o),
   .write_enable_n_o(write_enable_n_o), .ext_address_o(ext_address_o),
   .ext_bank_address_o(ext_bank_address_o));

// file: amst_sram_model.sv
// amst_sram_model.sv: behavioural asynchronous memory on the far side
`timescale 1ns/1ps
module amst_sram_model (
   input wire logic clk_i,
   input wire logic [3:0] cs_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [20:0] addr_i,
   input wire logic [15:0] data_i,
   input wire logic data_en_i,
   input wire logic stall_i,
   output logic [15:0] data_o,
   output logic wait_o
);
   logic [15:0] mem [0:15];
   logic [15:0] last_r = 16'h0000;
   logic sel;
   assign sel = cs_n_i != 4'hf;
   // a released bus shows the inverse of the last word, so stale data cannot match
   assign data_o = (sel && !oe_n_i) ? mem[addr_i[3:0]] : ~last_r;
   assign wait_o = stall_i;
   always @(posedge clk_i) begin
      if (sel && !oe_n_i) begin
         last_r <= mem[addr_i[3:0]];
      end
      // an undriven data bus stores garbage, caught on read back
      if (sel && !we_n_i) begin
         mem[addr_i[3:0]] <= data_en_i ? data_i : ~data_i;
      end
   end
endmodule : amst_sram_model

// file: amst_ctrl_tb.sv
// amst_ctrl_tb.sv: self-checking bench for the strobe sequencer
`timescale 1ns/1ps
module amst_ctrl_tb;
   import amst_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic req_valid_i = 1'b0;
   logic req_write_i = 1'b0;
   logic [20:0] req_addr_i = 21'h000000;
   logic [15:0] req_wdata_i = 16'h0000;
   logic ss = 1'b0;
   logic ew = 1'b0;
   logic stall = 1'b0;
   logic full_seen = 1'b0;
   amst_wcnt_t wlim = 8'h01;
   amst_cnt_t tc [7] = '{6'h02, 6'h02, 6'h03, 6'h01, 6'h01, 6'h02, 6'h02};
   logic req_ready_o, rsp_valid_o, rsp_timeout_o, busy_o, oe_n, we_n, d_oe, mwait;
   logic [15:0] rdata, mdata, wdo;
   logic [3:0] cs_n;
   logic [20:0] addr;
   logic [1:0] bank;
   int error_cnt = 0;
   int compares = 0;
   int oe_w;
   always #20 clk_i = ~clk_i;
   amst_ctrl dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_cs_i(req_addr_i[3:2]),
      .req_bank_i(req_addr_i[1:0]), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rdata), .rsp_timeout_o(rsp_timeout_o),
      .select_strobe_i(ss), .extended_wait_enable_i(ew), .wait_polarity_i(1'b0),
      .turnaround_cycles_i(tc[0]), .read_setup_cycles_i(tc[1]), .read_strobe_cycles_i(tc[2]),
      .read_hold_cycles_i(tc[3]), .write_setup_cycles_i(tc[4]), .write_strobe_cycles_i(tc[5]),
      .write_hold_cycles_i(tc[6]), .max_wait_limit_i(wlim), .busy_o(busy_o),
      .async_chip_select_n_o(cs_n), .output_enable_n_o(oe_n), .write_enable_n_o(we_n),
      .ext_address_o(addr), .ext_bank_address_o(bank), .ext_data_i(mdata), .ext_data_o(wdo),
      .ext_data_oe_o(d_oe), .memory_wait_in_i(mwait));
   amst_sram_model mem (.clk_i(clk_i), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .addr_i(addr), .data_i(wdo), .data_en_i(d_oe), .stall_i(stall), .data_o(mdata),
      .wait_o(mwait));
   // ---------------------------------------------
   // access tasks
   // ---------------------------------------------
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task results;
      if (error_cnt == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results
   // leaves valid high so back-to-back pushes never assign it twice in one step
   task push(input logic w, input logic [20:0] a, input logic [15:0] d);
      int n;
      n = 0;
      req_valid_i <= 1'b1;
      req_write_i <= w;
      req_addr_i <= a;
      req_wdata_i <= d;
      @(posedge clk_i);
      while (req_ready_o !== 1'b1) begin
         full_seen = 1'b1;
         n++;
         if (n > 300) begin
            chk("request bound", 0, 1);
            results();
         end
         @(posedge clk_i);
      end
   endtask : push
   task rd(input logic [20:0] a, input logic [15:0] exp, input logic tmo);
      int n;
      n = 0;
      oe_w = 0;
      push(1'b0, a, 16'h0000);
      req_valid_i <= 1'b0;
      while (rsp_valid_o !== 1'b1) begin
         @(posedge clk_i);
         if (oe_n === 1'b0) oe_w++;
         n++;
         if (n > 600) begin
            chk("read bound", 0, 1);
            results();
         end
      end
      if (!tmo) chk("read data", exp, rdata);
      chk("address held", a, addr);
      chk("bank held", a[1:0], bank);
      chk("busy after read", 0, busy_o);
      chk("timeout flag", tmo, rsp_timeout_o);
   endtask : rd
   initial begin
      repeat (2) @(posedge clk_i);
      chk("idle pins", 32'h3f, {cs_n, oe_n, we_n});
      nrst_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < 10; i++) push(1'b1, 21'(i), 16'(i) * 16'h1357);
      for (int i = 0; i < 10; i++) rd(21'(i), 16'(i) * 16'h1357, 1'b0);
      chk("fifo full seen", 1, full_seen);
      ss <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         push(1'b1, 21'(i + 4), 16'hbeef ^ 16'(i));
         rd(21'(i + 4), 16'hbeef ^ 16'(i), 1'b0);
      end
      ss <= 1'b0;
      ew <= 1'b1;
      stall <= 1'b1;
      rd(21'h000004, 16'h0000, 1'b1);
      chk("strobe with wait", 32'(tc[2]) + 32'd16, oe_w);
      stall <= 1'b0;
      rd(21'h000005, 16'hbeee, 1'b0);
      chk("strobe without wait", 32'(tc[2]), oe_w);
      results();
   end
endmodule : amst_ctrl_tb
